// [verilog/flash_regs_pkg.sv]
package flash_regs_pkg;

  // ==========================================================================
  // register indexes, byte address is four times the index
  localparam logic [3:0] IDX_CLKDIV    = 4'h0;
  localparam logic [3:0] IDX_SECURITY  = 4'h1;
  localparam logic [3:0] IDX_TEST      = 4'h2;
  localparam logic [3:0] IDX_CONFIG    = 4'h3;
  localparam logic [3:0] IDX_BANK_LO   = 4'h4;
  localparam logic [3:0] IDX_STATUS    = 4'h5;
  localparam logic [3:0] IDX_BANK_HI   = 4'hB;
  localparam logic [3:0] IDX_RSVD_A    = 4'hC;
  localparam logic [3:0] IDX_RSVD_B    = 4'hD;
  localparam logic [3:0] IDX_RSVD_C    = 4'hE;
  localparam logic [3:0] IDX_RSVD_D    = 4'hF;

  // ==========================================================================
  // bank structure
  localparam int         NUM_BANKS     = 2;
  localparam int         NUM_BANKED    = 8;

  // ==========================================================================
  // field positions
  localparam int         CLKDIV_LOADED = 7;
  localparam int         CLKDIV_PRE8   = 6;
  localparam int         SEC_KEY_HI    = 7;
  localparam int         SEC_KEY_LO    = 6;
  localparam int         TEST_WRITE_ALL_BANKS    = 4;
  localparam int         TEST_FORCE_DOUBLE_FAULT     = 3;
  localparam int         CFG_IRQ_EN    = 3;
  localparam int         CFG_BANK      = 0;
  localparam int         STAT_DFAULT   = 1;

  // ==========================================================================
  // codes and reset values
  localparam logic [1:0] KEY_ENABLED   = 2'h2;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [7:0] SEC_ALL_SET   = 8'hFF;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [7:0] RST_SECURITY  = 8'hFF;
  localparam logic [2:0] PRE_LAST      = 3'h7;
  localparam logic [15:0] CFG_ADDR     = 16'hFF0F;

endpackage : flash_regs_pkg

// [verilog/timing_tick_gen.sv]
`timescale 1ns/1ps
module timing_tick_gen (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // divider settings
  input  wire logic       run,
  input  wire logic       prescale_by_eight,
  input  wire logic [5:0] divide_field,
  // timing enable
  output logic            timing_tick
);

  typedef struct packed {
    logic [2:0] pre_cnt;
    logic [5:0] div_cnt;
    logic       tick;
  } tick_state_t;

  tick_state_t cur_ff;
  tick_state_t nxt_ff;
  logic        pre_tick;

  // ==========================================================================
  // prescale then programmable divide
  always_comb begin
    nxt_ff   = cur_ff;
    nxt_ff.tick = 1'b0;
    pre_tick = prescale_by_eight ? (cur_ff.pre_cnt == flash_regs_pkg::PRE_LAST) : 1'b1;
    if (!run) begin
      nxt_ff.pre_cnt = 3'h0;
      nxt_ff.div_cnt = 6'h00;
    end else begin
      nxt_ff.pre_cnt = prescale_by_eight ? cur_ff.pre_cnt + 3'h1 : 3'h0;
      if (pre_tick) begin
        if (cur_ff.div_cnt == divide_field) begin
          nxt_ff.div_cnt = 6'h00;
          nxt_ff.tick    = 1'b1;
        end else begin
          nxt_ff.div_cnt = cur_ff.div_cnt + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign timing_tick = cur_ff.tick;

endmodule : timing_tick_gen

// [verilog/flash_clock_security_test_regs.sv]
`timescale 1ns/1ps
module flash_clock_security_test_regs (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // chip mode pin
  input  wire logic        special_mode,
  // reset sequence load of the security byte
  input  wire logic        cfg_load,
  input  wire logic [7:0]  cfg_byte,
  input  wire logic        cfg_double_fault,
  // backdoor unlock result
  input  wire logic        backdoor_unlock_ok,
  // flash array read events
  input  wire logic        array_read_done,
  input  wire logic        array_double_fault,
  // block outputs
  output logic             timing_tick,
  output logic             backdoor_enabled,
  output logic             mcu_secured,
  output logic             write_all_banks,
  output logic             double_fault_flag,
  output logic             double_fault_irq,
  output logic             bank_select_field
);

  typedef struct packed {
    logic                                     mode_meta;
    logic                                     mode_sync;
    logic                                     ack;
    logic [31:0]                              rdata;
    logic                                     err;
    logic                                     divider_loaded_flag;
    logic                                     prescale_by_eight;
    logic [5:0]                               divide_field;
    logic [7:0]                               security_state;
    logic                                     write_all_banks;
    logic                                     force_double_fault;
    logic                                     double_fault_irq_enable;
    logic                                     bank_select_field;
    logic                                     double_fault_flag;
    logic [flash_regs_pkg::NUM_BANKS-1:0][flash_regs_pkg::NUM_BANKED-1:0][7:0] banked;
  } regs_state_t;

  regs_state_t cur_ff;
  regs_state_t nxt_ff;

  logic        access;
  logic        wr_commit;
  logic [3:0]  idx;
  logic        mapped;
  logic        is_banked;
  logic [2:0]  bank_slot;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic        df_event;

  // ==========================================================================
  // address decode
  always_comb begin
    idx       = paddr[5:2];
    mapped    = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0);
    is_banked = (idx >= flash_regs_pkg::IDX_BANK_LO) && (idx <= flash_regs_pkg::IDX_BANK_HI)
                && (idx != flash_regs_pkg::IDX_STATUS);
    bank_slot = 3'(idx - flash_regs_pkg::IDX_BANK_LO);
    wbyte     = pwdata[7:0];
  end

  // ==========================================================================
  // read data mux
  always_comb begin
    rbyte = flash_regs_pkg::RST_BYTE;
    if (idx == flash_regs_pkg::IDX_CLKDIV) begin
      rbyte = {cur_ff.divider_loaded_flag, cur_ff.prescale_by_eight,
               cur_ff.divide_field};
    end else if (idx == flash_regs_pkg::IDX_SECURITY) begin
      rbyte = cur_ff.security_state;
    end else if (idx == flash_regs_pkg::IDX_TEST) begin
      rbyte = flash_regs_pkg::RST_BYTE;
      rbyte[flash_regs_pkg::TEST_WRITE_ALL_BANKS] = cur_ff.write_all_banks & cur_ff.mode_sync;
      rbyte[flash_regs_pkg::TEST_FORCE_DOUBLE_FAULT]  = cur_ff.force_double_fault;
    end else if (idx == flash_regs_pkg::IDX_CONFIG) begin
      rbyte = flash_regs_pkg::RST_BYTE;
      rbyte[flash_regs_pkg::CFG_IRQ_EN] = cur_ff.double_fault_irq_enable;
      rbyte[flash_regs_pkg::CFG_BANK]   = cur_ff.bank_select_field;
    end else if (idx == flash_regs_pkg::IDX_STATUS) begin
      rbyte = flash_regs_pkg::RST_BYTE;
      rbyte[flash_regs_pkg::STAT_DFAULT] = cur_ff.double_fault_flag;
    end else if (is_banked) begin
      rbyte = cur_ff.banked[cur_ff.bank_select_field][bank_slot];
    end else begin
      rbyte = flash_regs_pkg::RST_BYTE;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    nxt_ff    = cur_ff;
    access    = psel && penable;
    wr_commit = access && cur_ff.ack && pwrite && mapped && pstrb[0];
    df_event  = array_read_done && (cur_ff.force_double_fault || array_double_fault);

    // chip mode synchroniser
    nxt_ff.mode_meta = special_mode;
    nxt_ff.mode_sync = cur_ff.mode_meta;

    // apb handshake, one wait state so read data comes from a flop
    if (access && !cur_ff.ack) begin
      nxt_ff.ack   = 1'b1;
      nxt_ff.err   = !mapped;
      nxt_ff.rdata = (!pwrite && mapped) ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end else begin
      nxt_ff.ack   = 1'b0;
      nxt_ff.err   = 1'b0;
    end

    // register writes
    if (wr_commit) begin
      if (idx == flash_regs_pkg::IDX_CLKDIV) begin
        if (!cur_ff.divider_loaded_flag) begin
          nxt_ff.prescale_by_eight = wbyte[flash_regs_pkg::CLKDIV_PRE8];
          nxt_ff.divide_field      = wbyte[5:0];
        end
        nxt_ff.divider_loaded_flag = 1'b1;
      end else if (idx == flash_regs_pkg::IDX_TEST) begin
        nxt_ff.force_double_fault = wbyte[flash_regs_pkg::TEST_FORCE_DOUBLE_FAULT];
        if (cur_ff.mode_sync) begin
          nxt_ff.write_all_banks = wbyte[flash_regs_pkg::TEST_WRITE_ALL_BANKS];
        end
      end else if (idx == flash_regs_pkg::IDX_CONFIG) begin
        nxt_ff.double_fault_irq_enable = wbyte[flash_regs_pkg::CFG_IRQ_EN];
        nxt_ff.bank_select_field       = wbyte[flash_regs_pkg::CFG_BANK];
      end else if (idx == flash_regs_pkg::IDX_STATUS) begin
        if (wbyte[flash_regs_pkg::STAT_DFAULT]) begin
          nxt_ff.double_fault_flag = 1'b0;
        end
      end else if (is_banked) begin
        for (int b = 0; b < flash_regs_pkg::NUM_BANKS; b++) begin
          if (cur_ff.write_all_banks || (1'(b) == cur_ff.bank_select_field)) begin
            nxt_ff.banked[b][bank_slot] = wbyte;
          end
        end
      end
    end

    // flag set wins over a clear in the same cycle
    if (df_event) begin
      nxt_ff.double_fault_flag = 1'b1;
    end

    // security byte: reset load and backdoor unlock
    if (cfg_load) begin
      nxt_ff.security_state = cfg_double_fault ? flash_regs_pkg::SEC_ALL_SET : cfg_byte;
    end else if (backdoor_unlock_ok) begin
      nxt_ff.security_state[1:0] = flash_regs_pkg::SEC_UNSECURED;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff                <= '0;
      cur_ff.security_state <= flash_regs_pkg::RST_SECURITY;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ==========================================================================
  // timing clock divider
  timing_tick_gen u_tick (
    .core_clk          (core_clk),
    .reset_n           (reset_n),
    .run               (cur_ff.divider_loaded_flag),
    .prescale_by_eight (cur_ff.prescale_by_eight),
    .divide_field      (cur_ff.divide_field),
    .timing_tick       (timing_tick)
  );

  // ==========================================================================
  // outputs
  assign pready            = psel && penable && cur_ff.ack;
  assign pslverr           = psel && penable && cur_ff.ack && cur_ff.err;
  assign prdata            = cur_ff.rdata;
  assign backdoor_enabled  = cur_ff.security_state[flash_regs_pkg::SEC_KEY_HI:
                                                   flash_regs_pkg::SEC_KEY_LO]
                             == flash_regs_pkg::KEY_ENABLED;
  assign mcu_secured       = cur_ff.security_state[1:0] != flash_regs_pkg::SEC_UNSECURED;
  assign write_all_banks   = cur_ff.write_all_banks;
  assign double_fault_flag = cur_ff.double_fault_flag;
  assign double_fault_irq  = cur_ff.double_fault_flag && cur_ff.double_fault_irq_enable;
  assign bank_select_field = cur_ff.bank_select_field;

endmodule : flash_clock_security_test_regs

// [tb/flash_regs_chk.sv]
`timescale 1ns/1ps
module flash_regs_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // security load and unlock
  input wire logic        cfg_load,
  input wire logic [7:0]  cfg_byte,
  input wire logic        cfg_double_fault,
  input wire logic        backdoor_unlock_ok,
  input wire logic        backdoor_enabled,
  input wire logic        mcu_secured,
  // double fault
  input wire logic        array_read_done,
  input wire logic        array_double_fault,
  input wire logic        double_fault_flag,
  input wire logic        double_fault_irq
);
  // ==========================================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_key_decode: assert property (
    cfg_load && !cfg_double_fault |=> backdoor_enabled == ($past(cfg_byte[7:6]) == 2'h2))
    else $error("backdoor enable does not follow loaded key code");
  a_sec_decode: assert property (
    cfg_load && !cfg_double_fault |=> mcu_secured == ($past(cfg_byte[1:0]) != 2'h2))
    else $error("secured state does not follow loaded security code");
  a_fault_secures: assert property (
    cfg_load && cfg_double_fault |=> mcu_secured && !backdoor_enabled)
    else $error("load fault did not secure the part");
  a_unlock_forces: assert property (
    backdoor_unlock_ok && !cfg_load |=> !mcu_secured)
    else $error("unlock did not unsecure");
  a_stay_secure: assert property (
    mcu_secured && !cfg_load && !backdoor_unlock_ok |=> mcu_secured)
    else $error("secured state changed without load or unlock");
  a_real_fault: assert property (
    array_read_done && array_double_fault |=> double_fault_flag)
    else $error("double fault did not set flag");
  a_irq_gate: assert property (double_fault_irq |-> double_fault_flag)
    else $error("interrupt without flag");
  a_ready_wait: assert property (
    $rose(penable) && psel |-> !pready ##1 pready ##1 !pready)
    else $error("access phase not one wait state");
  a_err_unmapped: assert property (
    pready |-> pslverr == (paddr[31:6] != 26'h000_0000 || paddr[1:0] != 2'h0))
    else $error("error response does not match address");
  c_load_fault: cover property (cfg_load && cfg_double_fault);
  c_unlock: cover property (backdoor_unlock_ok);
  c_irq: cover property (double_fault_irq);
endmodule : flash_regs_chk

bind flash_clock_security_test_regs flash_regs_chk flash_regs_chk_i (
  .core_clk, .reset_n, .psel, .penable, .paddr, .pready, .pslverr, .cfg_load, .cfg_byte,
  .cfg_double_fault, .backdoor_unlock_ok, .backdoor_enabled, .mcu_secured,
  .array_read_done, .array_double_fault, .double_fault_flag, .double_fault_irq);

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  // ==========================================================================
  // stimulus and observation
  logic        core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hf;
  logic        special_mode = 1'b0, cfg_load = 1'b0, cfg_double_fault = 1'b0;
  logic [7:0]  cfg_byte = 8'h00;
  logic        backdoor_unlock_ok = 1'b0, array_read_done = 1'b0, array_double_fault = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, timing_tick, backdoor_enabled, mcu_secured;
  wire         write_all_banks, double_fault_flag, double_fault_irq, bank_select_field;
  int          mismatches = 0, checks = 0;
  localparam logic [31:0] A_DIV  = {26'h000_0000, flash_regs_pkg::IDX_CLKDIV, 2'h0};
  localparam logic [31:0] A_SEC  = {26'h000_0000, flash_regs_pkg::IDX_SECURITY, 2'h0};
  localparam logic [31:0] A_TST  = {26'h000_0000, flash_regs_pkg::IDX_TEST, 2'h0};
  localparam logic [31:0] A_CFG  = {26'h000_0000, flash_regs_pkg::IDX_CONFIG, 2'h0};
  localparam logic [31:0] A_STA  = {26'h000_0000, flash_regs_pkg::IDX_STATUS, 2'h0};
  localparam logic [31:0] A_BANK = {26'h000_0000, flash_regs_pkg::IDX_BANK_LO, 2'h0};

  always #5 core_clk = ~core_clk;

  flash_clock_security_test_regs flash_clock_security_test_regs_i (
    .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .special_mode, .cfg_load, .cfg_byte, .cfg_double_fault, .backdoor_unlock_ok,
    .array_read_done, .array_double_fault, .timing_tick, .backdoor_enabled, .mcu_secured,
    .write_all_banks, .double_fault_flag, .double_fault_irq, .bank_select_field);

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // sampled right at the edge: the values seen are those the design had before it
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      results();
    end
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic       e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, exp);
    chk(e, 1'b0);
  endtask : rd

  task automatic ld(input logic [7:0] b, input logic f);
    @(posedge core_clk);
    cfg_byte <= b;
    cfg_double_fault <= f;
    cfg_load <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
    @(negedge core_clk);
  endtask : ld

  task automatic unlock();
    @(posedge core_clk);
    backdoor_unlock_ok <= 1'b1;
    @(posedge core_clk);
    backdoor_unlock_ok <= 1'b0;
    @(negedge core_clk);
  endtask : unlock

  task automatic array_read(input logic dbl);
    @(posedge core_clk);
    array_read_done <= 1'b1;
    array_double_fault <= dbl;
    @(posedge core_clk);
    array_read_done <= 1'b0;
    array_double_fault <= 1'b0;
    @(negedge core_clk);
  endtask : array_read

  task automatic tick_wait(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (timing_tick !== 1'b1 && n < 600);
    if (n >= 600) begin
      mismatches++;
      results();
    end
  endtask : tick_wait

  // ==========================================================================
  // scenarios
  task automatic t_clkdiv();
    int n;
    rd(A_DIV, 8'h00);
    wr(A_DIV, 8'h43);
    rd(A_DIV, 8'hC3);
    wr(A_DIV, 8'h05);
    rd(A_DIV, 8'hC3);
    tick_wait(n);
    tick_wait(n);
    chk(n, 32);
    // mid-run reset reopens the write-once divider, this time without the prescaler
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(A_DIV, 8'h00);
    wr(A_DIV, 8'h05);
    rd(A_DIV, 8'h85);
    tick_wait(n);
    tick_wait(n);
    chk(n, 6);
  endtask : t_clkdiv

  task automatic t_security();
    rd(A_SEC, flash_regs_pkg::RST_SECURITY);
    for (int i = 0; i < 4; i++) begin
      ld({2'(i), 4'hF, 2'(i)}, 1'b0);
      chk(backdoor_enabled, i == 2);
      chk(mcu_secured, i != 2);
    end
    ld(8'h3D, 1'b0);
    wr(A_SEC, 8'hBE);
    rd(A_SEC, 8'h3D);
    ld(8'hBE, 1'b1);
    rd(A_SEC, 8'hFF);
    unlock();
    rd(A_SEC, 8'hFE);
  endtask : t_security

  task automatic t_test_banks();
    wr(A_TST, 8'h18);
    rd(A_TST, 8'h08);
    chk(write_all_banks, 1'b0);
    wr(A_CFG, 8'h08);
    array_read(1'b0);
    chk({double_fault_flag, double_fault_irq}, 2'h3);
    wr(A_TST, 8'h00);
    rd(A_TST, 8'h00);
    wr(A_STA, 8'h02);
    array_read(1'b0);
    chk(double_fault_flag, 1'b0);
    array_read(1'b1);
    chk(double_fault_flag, 1'b1);
    wr(A_STA, 8'h02);
    chk(double_fault_flag, 1'b0);
    @(posedge core_clk);
    special_mode <= 1'b1;
    repeat (5) @(posedge core_clk);
    wr(A_TST, 8'h10);
    rd(A_TST, 8'h10);
    chk(write_all_banks, 1'b1);
    wr(A_BANK, 8'h5A);
    wr(A_CFG, 8'h01);
    chk(bank_select_field, 1'b1);
    rd(A_BANK, 8'h5A);
    wr(A_TST, 8'h00);
    wr(A_BANK, 8'h33);
    rd(A_BANK, 8'h33);
    wr(A_CFG, 8'h00);
    rd(A_BANK, 8'h5A);
  endtask : t_test_banks

  task automatic t_reserved();
    logic [7:0] r;
    logic       e;
    for (int i = 12; i < 16; i++) begin
      wr({26'h000_0000, 4'(i), 2'h0}, 8'hFF);
      rd({26'h000_0000, 4'(i), 2'h0}, 8'h00);
    end
    apb(1'b1, 32'h0000_0040, 8'h11, r, e);
    chk(e, 1'b1);
  endtask : t_reserved

  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    t_clkdiv();
    t_security();
    t_test_banks();
    t_reserved();
    results();
  end
endmodule : testbench
